// file: tsa_pkg.sv
// Function
// [R01] receive slot index picks one of 128 slots after frame sync
// [R02] unmasked receive slot width is width field plus one, 1 to 512 bits
// [R03] three-bit receive edge offset in bits 18..16 shifts the receive slot
// [R04] receive mask mode: 8-bit slots, index and offset place the mask
// [R05] mask mode receives only in slots whose mask bit is set
// [R06] transmit mask bit n selects 8-bit transmit slot n of 32
// [R07] transmit mask acts only in framed mode 5 with mask enable set
// [R08] transmit slot index sets distance from sync to mask slot zero
// [R09] receive mask bit n selects 8-bit receive slot n of 32
// [R10] receive mask acts only in framed mode 5 with mask enable set
// [R11] receive slot index sets distance from sync to mask slot zero
// [R12] slot settings are evaluated only in framed clock mode 5
// [R13] divider divides input clock by (N+1) times 2 to the M
// [R14] clock mode picks divider input source and output use; divider always counts clk, use_brg (ctrl bit 4) picks its use
// [R15] transmit slot index picks one of 128 slots after frame sync
// [R16] unmasked transmit slot width is width field plus one bits
// [R17] unused register bits read zero and ignore writes
package tsa_pkg;
    localparam logic [11:0] ADDR_RX_SLOT_ASSIGN = 12'h0120;
    localparam logic [11:0] ADDR_TX_SLOT_MASK = 12'h0124;
    localparam logic [11:0] ADDR_RX_SLOT_MASK = 12'h0128;
    localparam logic [11:0] ADDR_BIT_RATE_DIVIDER = 12'h012c;
    localparam logic [11:0] ADDR_TX_SLOT_ASSIGN = 12'h011c;
    localparam logic [11:0] ADDR_CHAN_CTRL = 12'h0140;
    localparam logic [11:0] ADDR_CHAN_STATUS = 12'h0144;
    localparam logic [31:0] SLOT_ASSIGN_MASK = 32'h7f07_81ff;
    localparam logic [31:0] DIVIDER_MASK = 32'h0000_0f3f;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0017;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [2:0] CLOCK_MODE_FRAMED = 3'h5;
    localparam int SLOT_BITS = 8;
    localparam int MASK_SLOTS = 32;

    typedef struct packed {
        logic zero0;
        logic [6:0] slot_index;
        logic [4:0] zero1;
        logic [2:0] edge_offset;
        logic mask_enable;
        logic [5:0] zero2;
        logic [8:0] width_field;
    } slot_assign_t;

    typedef struct packed {
        logic [19:0] zero0;
        logic [3:0] divider_exponent;
        logic [1:0] zero1;
        logic [5:0] divider_mantissa;
    } divider_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_OFFSET, ST_SLOTS} slot_state_t;
endpackage

// file: slot_gate.sv
`timescale 1ns/100ps
`default_nettype none
// one direction of slot selection, counted in serial bit clock ticks
module slot_gate
    import tsa_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic sync,
    input wire logic framed,
    input wire tsa_pkg::slot_assign_t cfg,
    input wire logic [31:0] mask,
    output logic active
);
    slot_state_t state_r;
    logic [15:0] cnt_r;
    logic [8:0] bit_r;
    logic [4:0] slot_r;
    logic [15:0] offset;
    logic [8:0] width;

    // mask mode uses 8-bit slots and ignores width field
    assign width = cfg.mask_enable ? 9'(SLOT_BITS - 1) : cfg.width_field; // [R02] [R04] [R16]
    // distance from sync: slot index times width plus edge offset, up to 127*512+7
    assign offset = 16'(cfg.slot_index) * (16'(width) + 16'd1) + 16'(cfg.edge_offset); // [R01] [R03] [R11] [R08] [R15]

    // frame walker
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            bit_r <= '0;
            slot_r <= '0;
            active <= 1'b0;
        end
        else if (!framed)
        begin
            state_r <= ST_IDLE; // [R12]
            active <= 1'b0;
        end
        else if (tick)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    active <= 1'b0;
                    if (sync)
                    begin
                        cnt_r <= '0;
                        bit_r <= '0;
                        slot_r <= '0;
                        if (offset == 16'd0)
                        begin
                            state_r <= ST_SLOTS;
                            active <= cfg.mask_enable ? mask[0] : 1'b1; // [R05] [R09]
                        end
                        else
                            state_r <= ST_OFFSET;
                    end
                end
                ST_OFFSET:
                begin
                    cnt_r <= cnt_r + 16'd1;
                    if (cnt_r + 16'd1 == offset)
                    begin
                        state_r <= ST_SLOTS;
                        active <= cfg.mask_enable ? mask[0] : 1'b1;
                    end
                end
                ST_SLOTS:
                begin
                    if (bit_r == width)
                    begin
                        bit_r <= '0;
                        if (!cfg.mask_enable || slot_r == 5'(MASK_SLOTS - 1))
                        begin
                            state_r <= ST_IDLE;
                            active <= 1'b0;
                        end
                        else
                        begin
                            slot_r <= slot_r + 5'd1;
                            active <= mask[slot_r + 5'd1]; // [R05] [R06] [R09]
                        end
                    end
                    else
                        bit_r <= bit_r + 9'd1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // unmasked mode never advances past slot zero
    property p_unmasked_single;
        @(posedge clk) disable iff (!resetn)
        (state_r == ST_SLOTS && !cfg.mask_enable) |-> slot_r == 5'd0;
    endproperty
    a_unmasked_single: assert property (p_unmasked_single) else $error("slot advanced"); // [R02]

    property p_off_when_unframed;
        @(posedge clk) disable iff (!resetn)
        !framed |=> !active;
    endproperty
    a_off_when_unframed: assert property (p_off_when_unframed) else $error("active out of mode"); // [R12]
endmodule
`default_nettype wire

// file: tsa_channel.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// slot selection and baud divider for one serial channel
module tsa_channel
    import tsa_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire tsa_pkg::reg_req_t req,
    output logic [31:0] rdata,
    input wire logic serial_clk_pin,
    input wire logic frame_sync_pin,
    output logic rx_active,
    output logic tx_active,
    output logic baud_tick,
    output logic bit_tick
);
    import tsa_pkg::*;

    // =====================================================
    // registers
    slot_assign_t rx_assign_r;
    slot_assign_t tx_assign_r;
    logic [31:0] tx_mask_r;
    logic [31:0] rx_mask_r;
    divider_t div_r;
    logic [31:0] ctrl_r;
    logic framed;
    logic use_brg;

    assign framed = ctrl_r[2:0] == CLOCK_MODE_FRAMED; // [R12] [R14]
    assign use_brg = ctrl_r[4];

    // register writes, unused bits dropped
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_assign_r <= RESET_VALUE;
            tx_assign_r <= RESET_VALUE;
            tx_mask_r <= RESET_VALUE;
            rx_mask_r <= RESET_VALUE;
            div_r <= RESET_VALUE;
            ctrl_r <= RESET_VALUE;
        end
        else if (req.wr)
        begin
            case (req.addr)
                ADDR_RX_SLOT_ASSIGN: rx_assign_r <= req.wdata & SLOT_ASSIGN_MASK; // [R17]
                ADDR_TX_SLOT_ASSIGN: tx_assign_r <= req.wdata & SLOT_ASSIGN_MASK; // [R17]
                ADDR_TX_SLOT_MASK: tx_mask_r <= req.wdata; // [R06]
                ADDR_RX_SLOT_MASK: rx_mask_r <= req.wdata; // [R09]
                ADDR_BIT_RATE_DIVIDER: div_r <= req.wdata & DIVIDER_MASK; // [R17]
                ADDR_CHAN_CTRL: ctrl_r <= req.wdata & CTRL_MASK;
                default: ;
            endcase
        end
    end

    // =====================================================
    // pin synchronisers
    logic [1:0] sclk_s;
    logic [1:0] fs_s;
    logic sclk_d;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_s <= '0;
            fs_s <= '0;
            sclk_d <= 1'b0;
        end
        else
        begin
            sclk_s <= {sclk_s[0], serial_clk_pin};
            fs_s <= {fs_s[0], frame_sync_pin};
            sclk_d <= sclk_s[1];
        end
    end

    // =====================================================
    // baud divider: prescale by 2^M then by N+1
    logic [14:0] pre_r;
    logic [5:0] div_cnt_r;
    logic pre_done;
    logic [14:0] pre_limit;

    assign pre_limit = 15'((16'd1 << div_r.divider_exponent) - 16'd1);
    // compare with >= so a smaller new setting never waits for a counter wrap
    assign pre_done = pre_r >= pre_limit;

    // divide clk by (N+1)*2^M
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre_r <= '0;
            div_cnt_r <= '0;
            baud_tick <= 1'b0;
        end
        else
        begin
            baud_tick <= 1'b0;
            if (pre_done)
            begin
                pre_r <= '0;
                if (div_cnt_r >= div_r.divider_mantissa)
                begin
                    div_cnt_r <= '0;
                    baud_tick <= 1'b1; // [R13]
                end
                else
                    div_cnt_r <= div_cnt_r + 6'd1;
            end
            else
                pre_r <= pre_r + 15'd1;
        end
    end

    // bit clock: divider output or serial clock rising edge
    logic tick_nxt;
    assign tick_nxt = use_brg ? baud_tick : (sclk_s[1] & ~sclk_d); // [R14]

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            bit_tick <= 1'b0;
        else
            bit_tick <= tick_nxt;
    end

    // =====================================================
    // slot walkers
    logic rx_gate;
    logic tx_gate;

    slot_gate u_rx (
        .clk(clk),
        .resetn(resetn),
        .tick(tick_nxt),
        .sync(fs_s[1]),
        .framed(framed),
        .cfg(rx_assign_r),
        .mask(rx_mask_r),
        .active(rx_gate)
    ); // [R10]

    slot_gate u_tx (
        .clk(clk),
        .resetn(resetn),
        .tick(tick_nxt),
        .sync(fs_s[1]),
        .framed(framed),
        .cfg(tx_assign_r),
        .mask(tx_mask_r),
        .active(tx_gate)
    ); // [R07]

    // outputs from flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_active <= 1'b0;
            tx_active <= 1'b0;
        end
        else
        begin
            rx_active <= rx_gate;
            tx_active <= tx_gate;
        end
    end

    // =====================================================
    // read path, data one cycle after strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= RESET_VALUE;
        else if (req.rd)
        begin
            case (req.addr)
                ADDR_RX_SLOT_ASSIGN: rdata <= rx_assign_r; // [R17]
                ADDR_TX_SLOT_ASSIGN: rdata <= tx_assign_r;
                ADDR_TX_SLOT_MASK: rdata <= tx_mask_r;
                ADDR_RX_SLOT_MASK: rdata <= rx_mask_r;
                ADDR_BIT_RATE_DIVIDER: rdata <= div_r;
                ADDR_CHAN_CTRL: rdata <= ctrl_r;
                ADDR_CHAN_STATUS: rdata <= {28'h000_0000, framed, bit_tick, tx_gate, rx_gate};
                default: rdata <= RESET_VALUE;
            endcase
        end
        else
            rdata <= RESET_VALUE;
    end

    // =====================================================
    // checks
    property p_div_unity;
        @(posedge clk) disable iff (!resetn)
        (div_r == RESET_VALUE && $past(div_r) == RESET_VALUE) |=> baud_tick;
    endproperty
    a_div_unity: assert property (p_div_unity) else $error("k=1 not every cycle"); // [R13]

    property p_div_two;
        @(posedge clk) disable iff (!resetn)
        (div_r.divider_exponent == 4'd1 && div_r.divider_mantissa == 6'd0 && baud_tick
         && $stable(div_r)) |=> !baud_tick ##1 baud_tick;
    endproperty
    a_div_two: assert property (p_div_two) else $error("k=2 wrong"); // [R13]

    property p_unused_read_zero;
        @(posedge clk) disable iff (!resetn)
        (req.rd && req.addr == ADDR_BIT_RATE_DIVIDER) |=> (rdata & ~DIVIDER_MASK) == 32'h0000_0000;
    endproperty
    a_unused_read_zero: assert property (p_unused_read_zero) else $error("unused bits set"); // [R17]

    property p_rx_mode5;
        @(posedge clk) disable iff (!resetn)
        !framed ##1 !framed |=> !rx_active;
    endproperty
    a_rx_mode5: assert property (p_rx_mode5) else $error("rx outside mode 5"); // [R10]

    property p_tx_mode5;
        @(posedge clk) disable iff (!resetn)
        !framed ##1 !framed |=> !tx_active;
    endproperty
    a_tx_mode5: assert property (p_tx_mode5) else $error("tx outside mode 5"); // [R07]

    property p_read_idle;
        @(posedge clk) disable iff (!resetn)
        !req.rd |=> rdata == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("rdata without read"); // [R17]

    // receive mask takes the full written word
    property p_rx_mask_write;
        @(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == ADDR_RX_SLOT_MASK) |=> rx_mask_r == $past(req.wdata);
    endproperty
    a_rx_mask_write: assert property (p_rx_mask_write) else $error("rx mask write lost"); // [R09]

    // transmit mask takes the full written word
    property p_tx_mask_write;
        @(posedge clk) disable iff (!resetn)
        (req.wr && req.addr == ADDR_TX_SLOT_MASK) |=> tx_mask_r == $past(req.wdata);
    endproperty
    a_tx_mask_write: assert property (p_tx_mask_write) else $error("tx mask write lost"); // [R06]

    // reserved receive assignment bits never hold a one
    property p_assign_clean;
        @(posedge clk) disable iff (!resetn)
        (rx_assign_r & ~SLOT_ASSIGN_MASK) == 32'h0000_0000;
    endproperty
    a_assign_clean: assert property (p_assign_clean) else $error("assign reserved set"); // [R17]

    // reserved divider bits never hold a one
    property p_div_clean;
        @(posedge clk) disable iff (!resetn)
        (div_r & ~DIVIDER_MASK) == 32'h0000_0000;
    endproperty
    a_div_clean: assert property (p_div_clean) else $error("divider reserved set"); // [R17]

    // any factor above one leaves a gap after each pulse
    property p_baud_gap;
        @(posedge clk) disable iff (!resetn)
        (baud_tick && $stable(div_r) && div_r != RESET_VALUE) |=> !baud_tick;
    endproperty
    a_baud_gap: assert property (p_baud_gap) else $error("baud pulses adjacent"); // [R13]

    // divider output drives the bit clock when selected
    property p_bit_from_brg;
        @(posedge clk) disable iff (!resetn)
        use_brg |=> bit_tick == $past(baud_tick);
    endproperty
    a_bit_from_brg: assert property (p_bit_from_brg) else $error("bit tick not from divider"); // [R14]

    // status shows whether framed mode is on
    property p_status_framed;
        @(posedge clk) disable iff (!resetn)
        (req.rd && req.addr == ADDR_CHAN_STATUS) |=> rdata[3] == $past(framed);
    endproperty
    a_status_framed: assert property (p_status_framed) else $error("status mode wrong"); // [R12]

    // receive assignment readback returns the stored fields
    property p_assign_read;
        @(posedge clk) disable iff (!resetn)
        (req.rd && req.addr == ADDR_RX_SLOT_ASSIGN) |=> rdata == $past(rx_assign_r);
    endproperty
    a_assign_read: assert property (p_assign_read) else $error("assign readback wrong"); // [R01]
endmodule
`default_nettype wire

// file: serial_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far-side framed serial line
// bit clock runs only inside a frame and rests low between frames
module serial_line_model
#(
    parameter int HALF = 4
)
(
    input wire logic clk,
    input wire logic go,
    input wire logic [10:0] nbits,
    output logic sclk,
    output logic fsync,
    output logic busy
);
    initial
    begin
        sclk = 1'b0;
        fsync = 1'b0;
        busy = 1'b0;
    end

    // one frame: sync held across the first clock rise, then nbits more bits
    always @(posedge clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            fsync <= 1'b1;
            for (int i = 0; i <= int'(nbits); i++)
            begin
                repeat (HALF) @(posedge clk);
                sclk <= 1'b1;
                repeat (HALF) @(posedge clk);
                sclk <= 1'b0;
                fsync <= 1'b0;
            end
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: timeslot_select_and_baud_divider_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timeslot_select_and_baud_divider_tb;
    import tsa_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req = '0;
    logic [31:0] rdata;
    logic sclk, fsync, busy, rx_active, tx_active, baud_tick, bit_tick;
    logic go = 1'b0;
    logic [10:0] nbits = '0;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    integer seed = 32'hddd2;
    logic [31:0] v;
    logic [31:0] w;
    logic [11:0] addrs [5] = '{ADDR_RX_SLOT_ASSIGN, ADDR_TX_SLOT_ASSIGN, ADDR_RX_SLOT_MASK,
        ADDR_TX_SLOT_MASK, ADDR_BIT_RATE_DIVIDER};
    logic [31:0] keep [5] = '{SLOT_ASSIGN_MASK, SLOT_ASSIGN_MASK, 32'hffff_ffff,
        32'hffff_ffff, DIVIDER_MASK};

    always #5 clk = ~clk;

    tsa_channel dut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
        .serial_clk_pin(sclk), .frame_sync_pin(fsync), .rx_active(rx_active),
        .tx_active(tx_active), .baud_tick(baud_tick), .bit_tick(bit_tick));
    serial_line_model far (.clk(clk), .go(go), .nbits(nbits), .sclk(sclk),
        .fsync(fsync), .busy(busy));

    // ==========================================================
    // monitors
    // count slot bits on settled bit ticks
    always @(negedge clk)
    begin
        if (bit_tick === 1'b1)
        begin
            rx_cnt += (rx_active === 1'b1);
            tx_cnt += (tx_active === 1'b1);
        end
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ==========================================================
    // tasks
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic slot_assign_t rnd_cfg(input logic en);
        slot_assign_t c;
        logic [31:0] r;
        r = $random(seed);
        c = '0;
        c.slot_index = {4'h0, r[2:0]};
        c.edge_offset = r[6:4];
        c.mask_enable = en;
        c.width_field = {3'h0, r[13:8]};
        return c;
    endfunction

    function automatic int slot_bits(input slot_assign_t c, input logic [31:0] m);
        return c.mask_enable ? SLOT_BITS * $countones(m) : int'(c.width_field) + 1;
    endfunction

    function automatic int span(input slot_assign_t c);
        if (c.mask_enable)
            return int'(c.slot_index) * SLOT_BITS + int'(c.edge_offset) + 256 + 16;
        return int'(c.slot_index) * (int'(c.width_field) + 1) + int'(c.edge_offset)
            + int'(c.width_field) + 1 + 16;
    endfunction

    // one frame from the far side, then wait for the synchronisers to drain
    task automatic frame(input int len);
        rx_cnt = 0;
        tx_cnt = 0;
        @(posedge clk);
        nbits <= len[10:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 20000 && busy; i++)
            @(posedge clk);
        repeat (8) @(posedge clk);
    endtask

    task automatic slot_test(input logic [2:0] mode, input slot_assign_t r, input slot_assign_t t,
        input logic [31:0] rm, input logic [31:0] tm);
        int len;
        logic fr;
        fr = (mode == CLOCK_MODE_FRAMED);
        wr(ADDR_CHAN_CTRL, {29'h0, mode});
        wr(ADDR_RX_SLOT_ASSIGN, r);
        wr(ADDR_TX_SLOT_ASSIGN, t);
        wr(ADDR_RX_SLOT_MASK, rm);
        wr(ADDR_TX_SLOT_MASK, tm);
        len = (span(r) > span(t)) ? span(r) : span(t);
        frame(len);
        check(rx_cnt, fr ? slot_bits(r, rm) : 0, "rx slot bits");
        check(tx_cnt, fr ? slot_bits(t, tm) : 0, "tx slot bits");
        $display("slot test mode %0d done", mode);
    endtask

    // pulses counted over four periods after a settled pulse
    task automatic baud_test(input logic [5:0] n, input logic [1:0] m);
        int k;
        int cnt;
        int bcnt;
        k = (int'(n) + 1) << m;
        cnt = 0;
        bcnt = 0;
        wr(ADDR_BIT_RATE_DIVIDER, {20'h0, 2'b00, m, 2'b00, n});
        repeat (2)
        begin
            @(negedge clk);
            for (int j = 0; j < 2000 && baud_tick !== 1'b1; j++)
                @(negedge clk);
        end
        repeat (4 * k)
        begin
            @(negedge clk);
            cnt += (baud_tick === 1'b1);
            bcnt += (bit_tick === 1'b1);
        end
        check(cnt, 4, "baud pulses");
        check(bcnt, 4, "bit ticks from divider");
        $display("baud test k=%0d done", k);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        slot_assign_t c;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            rd(addrs[i], v);
            check(v, RESET_VALUE, "reset value");
            wr(addrs[i], 32'hffff_ffff);
            rd(addrs[i], v);
            check(v, keep[i], "ones readback");
            w = $random(seed);
            wr(addrs[i], w);
            rd(addrs[i], v);
            check(v, w & keep[i], "random readback");
        end
        wr(12'h0130, 32'hffff_ffff);
        rd(12'h0130, v);
        check(v, 32'h0000_0000, "unmapped read");
        $display("register test done");
        wr(ADDR_CHAN_CTRL, 32'h0000_0010);
        baud_test(6'h00, 2'h0);
        baud_test(6'h00, 2'h1);
        baud_test(6'h3f, 2'h3);
        repeat (3)
        begin
            w = $random(seed);
            baud_test(w[5:0], w[9:8]);
        end
        slot_test(CLOCK_MODE_FRAMED, rnd_cfg(1'b0), rnd_cfg(1'b0), 32'h0, 32'h0);
        slot_test(CLOCK_MODE_FRAMED, rnd_cfg(1'b0), rnd_cfg(1'b0), 32'h0, 32'h0);
        c = '0;
        c.edge_offset = 3'h7;
        c.width_field = 9'h1ff;
        slot_test(CLOCK_MODE_FRAMED, c, rnd_cfg(1'b0), 32'h0, 32'h0);
        slot_test(CLOCK_MODE_FRAMED, rnd_cfg(1'b1), rnd_cfg(1'b1), $random(seed), $random(seed));
        slot_test(CLOCK_MODE_FRAMED, rnd_cfg(1'b1), rnd_cfg(1'b1), 32'hffff_ffff, 32'h8000_0001);
        slot_test(CLOCK_MODE_FRAMED, rnd_cfg(1'b1), rnd_cfg(1'b0), 32'h0, 32'hffff_ffff);
        slot_test(3'h0, rnd_cfg(1'b1), rnd_cfg(1'b0), 32'hffff_ffff, 32'hffff_ffff);
        slot_test(3'h4, rnd_cfg(1'b0), rnd_cfg(1'b1), 32'hffff_ffff, 32'hffff_ffff);
        report_and_stop();
    end
endmodule
`default_nettype wire
